// >>> logic/scgsb_pkg.sv
// Package: map, field layout, reset values and carriers of the control bank
package scgsb_pkg;

    // ====================================================================
    // Register byte offsets
    localparam logic [11:0] OFS_PAD_OVERRIDE = 12'h40C; // Software pad override
    localparam logic [11:0] OFS_IDLE_REQ     = 12'h414; // Sleep requests
    localparam logic [11:0] OFS_IDLE_POLICY  = 12'h418; // Stall or error policy
    localparam logic [11:0] OFS_MISC_CLK     = 12'h41C; // Misc clock word
    localparam logic [11:0] OFS_TEMP_HIGH    = 12'h420; // Sensor test high
    localparam logic [11:0] OFS_TEMP_LOW     = 12'h424; // Sensor test low
    localparam logic [11:0] OFS_PAD_ROUTE    = 12'h428; // Pad routing word
    localparam logic [11:0] OFS_STATUS       = 12'h480; // Status snapshot
    localparam logic [11:0] OFS_ACK_STATUS   = 12'h484; // Acknowledge status

    // ====================================================================
    // Field positions
    localparam int MASK_LSB        = 16; // Write mask half
    localparam int CTL_WIDTH       = 16; // Writable lower half
    localparam int SLEEP_UNITS     = 10; // Interface units
    localparam int MISC_FUSE_DIV   = 2;
    localparam int MISC_PLL_CLAMP  = 1;
    localparam int MISC_CARD_INV   = 0;
    localparam int OVR_DDC_DATA    = 1;
    localparam int OVR_DDC_CLOCK   = 0;
    localparam int RT_COND_LSB     = 12; // Input conditioning 15:12
    localparam int RT_PULL_LSB     = 10; // Pull setting 11:10
    localparam int RT_CARD_PWR     = 9;
    localparam int RT_DDC_DATA     = 8;
    localparam int RT_DDC_CLOCK    = 7;
    localparam int RT_TEMP_CLK     = 6;
    localparam int RT_WIFI_SRC     = 5;
    localparam int RT_AUDIO_LSB    = 2;  // Audio output disables 4:2
    localparam int RT_AON_OUT      = 1;
    localparam int RT_AON_OE_N     = 0;

    // ====================================================================
    // Reset values
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    localparam logic [15:0] RST_PAD_ROUTE = 16'hF800; // 15:12 and 11 set
    localparam logic [2:0]  RST_MISC      = 3'h0;

    // ====================================================================
    // Pad owner and carriers
    typedef enum logic [1:0] {
        OWN_HDMI   = 2'b00, // Display controller
        OWN_SERIAL = 2'b01, // Serial bus controller
        OWN_SW     = 2'b10  // Software pad control
    } scgsb_owner_e;

    typedef struct packed {
        logic       encoderVideoQuiet;
        logic       audioCodecMasterFlag;
        logic       internalMacPhyMode;    // 1 MII, 0 GMII
        logic       vdacCableDetect;
        logic       dispDmaDone;
        logic [5:0] timerRunning;          // Timer 5 down to 0
        logic       externalMacPortMode;
        logic       fuseProgBusyNonsecure;
        logic       fuseUserBusyNonsecure;
        logic       fuseProgBusySecure;
    } scgsb_status_s;

    typedef struct packed {
        scgsb_owner_e ddcDataOwner;
        scgsb_owner_e ddcClockOwner;
        logic         cardPowerPrimary;    // 1 primary, 0 external
        logic         tempConvClockInvert; // 1 while inverting
        logic         wifiClkFromOsc;      // 1 oscillator source
        logic [2:0]   audioOutDisable;     // 1 disables the line
        logic         aonPadOut;
        logic         aonPadOutEnN;        // Low drives the pad
        logic [1:0]   aonPadPull;
        logic [3:0]   ddcInputCond;        // Data, clock, hotplug, cec
    } scgsb_pad_s;

endpackage : scgsb_pkg

// >>> logic/scgsb_mask_reg.sv
// Module: control word with per-bit write mask in the upper half
`timescale 1ns/1ps
`default_nettype none

module scgsb_mask_reg
    import scgsb_pkg::*;
#(
    parameter int          WIDTH     = 16,      // Stored bits
    parameter logic [15:0] RESET_VAL = 16'h0000 // Value after reset
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             wrEn,  // One access-phase write
    input  wire logic [31:0]      wdata, // Mask in 31:16, data in 15:0
    output logic      [WIDTH-1:0] value
);

    // ====================================================================
    // One flip-flop per bit, gated by its own mask bit
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : gBit
            // Bit moves only when its mask bit is set
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    value[b] <= RESET_VAL[b];
                end else if (wrEn && wdata[MASK_LSB + b]) begin
                    value[b] <= wdata[b];
                end
            end
        end
    endgenerate

endmodule : scgsb_mask_reg

`default_nettype wire

// >>> logic/scgsb_bank.sv
// Module: general control and status register bank behind an APB slave
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Mask bit n+16 gates write of bit n, except in the misc word
// - Ten bits request sleep of interface units
// - Sixteen bits: 0 error, 1 stall response
// - Misc bit 2 halves fuse clock rate
// - Misc bit 1 enables PLL clamp
// - Misc bit 0 inverts card detect input
// - Two 16-bit sensor test words, reset zero
// - Data pad: override, else serial or display
// - Clock pad: override, else serial or display
// - Route bit 9 picks card power source
// - Route bit 6 low inverts converter clock
// - Route bit 5 picks wireless clock source
// - Bits 4:2 disable audio outputs when set
// - Bit 1 pad value, bit 0 enable low
// - Pull bits 11:10 reset to 1 and 0
// - Conditioning bits 15:12 reset to one
// - Status 26:22 show pad input levels
// - Status 16:11 show timer enables
// - Status 20 and 10 show MAC modes
// - Status 19 detect, 18 DMA done; 17, 31:28 zero
// - Status 9:7 fuse busy, 27, 21 flags
// - Acknowledge status reads 0 when asserted

module scgsb_bank
    import scgsb_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic [11:0]   paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire scgsb_status_s statusIn,         // Same-clock status
    input  wire logic [9:0]    sleepAcknowledge, // Low while acknowledged
    input  wire logic [4:0]    padLevelPin,      // Cec, hpd, sda, scl, aon
    input  wire logic          cardDetectPin,    // Raw card detect pin
    output logic [9:0]         sleepReq,
    output logic [5:0]         sleepPolicyA,     // Upper policy bits 15:10
    output logic [15:0]        sleepAccessStallSel,
    output logic               fuseUserClkEn,    // Fuse clock enable pulse
    output logic               pllClampEn,
    output logic               cardDetect,       // Conditioned card detect
    output logic [15:0]        tempTestHigh,
    output logic [15:0]        tempTestLow,
    output scgsb_pad_s         padCtrl
);

    // ====================================================================
    // Bus phase decode
    logic        setupPhase;  // First cycle of a transfer
    logic        wrAccess;    // Write completes this edge
    logic        addrHit;     // Address maps to a register
    logic [31:0] readWord;    // Word selected for read

    assign setupPhase = psel && !penable;
    assign wrAccess   = psel && penable && pready && pwrite;
    // Writes land only at the access edge, so a
    // setup cycle cannot disturb a stored word

    // Per-register write strobes; exact compare,
    // so unlisted addresses hit nothing
    logic wrOverride;
    logic wrIdleReq;
    logic wrPolicy;
    logic wrMisc;
    logic wrTempHigh;
    logic wrTempLow;
    logic wrRoute;

    assign wrOverride = wrAccess && (paddr == OFS_PAD_OVERRIDE);
    assign wrIdleReq  = wrAccess && (paddr == OFS_IDLE_REQ);
    assign wrPolicy   = wrAccess && (paddr == OFS_IDLE_POLICY);
    assign wrMisc     = wrAccess && (paddr == OFS_MISC_CLK);
    assign wrTempHigh = wrAccess && (paddr == OFS_TEMP_HIGH);
    assign wrTempLow  = wrAccess && (paddr == OFS_TEMP_LOW);
    assign wrRoute    = wrAccess && (paddr == OFS_PAD_ROUTE);

    // ====================================================================
    // Masked control words and the unmasked misc word
    // Only the data half is kept; masks act once
    logic [15:0] idleReqWord;  // Sleep requests and upper policy
    logic [15:0] policyWord;   // Stall or error per link
    logic [15:0] routeWord;    // Pad routing word
    logic [1:0]  overrideWord; // Software pad overrides
    logic [2:0]  miscWord;     // Unmasked misc clock bits

    // Sleep requests in 9:0, policy bits above
    scgsb_mask_reg #(
        .WIDTH     (CTL_WIDTH),
        .RESET_VAL (RST_ZERO)
    ) uIdleReq (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrIdleReq),
        .wdata (pwdata),
        .value (idleReqWord)
    );

    // Response policy while idle
    scgsb_mask_reg #(
        .WIDTH     (CTL_WIDTH),
        .RESET_VAL (RST_ZERO)
    ) uPolicy (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrPolicy),
        .wdata (pwdata),
        .value (policyWord)
    );

    // Sensor test word, high half
    scgsb_mask_reg #(
        .WIDTH     (CTL_WIDTH),
        .RESET_VAL (RST_ZERO)
    ) uTempHigh (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrTempHigh),
        .wdata (pwdata),
        .value (tempTestHigh)
    );

    // Sensor test word, low half
    scgsb_mask_reg #(
        .WIDTH     (CTL_WIDTH),
        .RESET_VAL (RST_ZERO)
    ) uTempLow (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrTempLow),
        .wdata (pwdata),
        .value (tempTestLow)
    );

    // Pad routing; conditioning bits and pull bit 11 reset high, pull bit 10 low
    scgsb_mask_reg #(
        .WIDTH     (CTL_WIDTH),
        .RESET_VAL (RST_PAD_ROUTE)
    ) uRoute (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrRoute),
        .wdata (pwdata),
        .value (routeWord)
    );

    // Software override of the two display pads
    scgsb_mask_reg #(
        .WIDTH     (2),
        .RESET_VAL (RST_ZERO)
    ) uOverride (
        .clk   (clk),
        .rstn  (rstn),
        .wrEn  (wrOverride),
        .wdata (pwdata),
        .value (overrideWord)
    );

    // Misc clock word has no mask: plain write of bits 2:0
    // Bits 31:3 are never stored, so read zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            miscWord <= RST_MISC;
        end else if (wrMisc) begin
            miscWord <= pwdata[2:0];
        end
    end

    // Stored words drive their outputs straight from the flops
    // A second stage would only add lag
    // Upper policy bits share the request word
    assign sleepReq            = idleReqWord[SLEEP_UNITS-1:0];
    assign sleepPolicyA        = idleReqWord[15:10];
    assign sleepAccessStallSel = policyWord;
    assign pllClampEn          = miscWord[MISC_PLL_CLAMP];

    // ====================================================================
    // Pin synchronisers
    logic [4:0] padMeta;  // First stage, read only by second
    logic [4:0] padSync;  // Stable pad levels
    logic       cardMeta; // First stage of card detect
    logic       cardSync; // Stable card detect

    // Two flops per asynchronous pin
    // Pins are off clk; status lags two cycles
    // Logic reads only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            padMeta  <= 5'h00;
            padSync  <= 5'h00;
            cardMeta <= 1'b0;
            cardSync <= 1'b0;
        end else begin
            padMeta  <= padLevelPin;
            padSync  <= padMeta;
            cardMeta <= cardDetectPin;
            cardSync <= cardMeta;
        end
    end

    // ====================================================================
    // Derived pad and clock controls
    scgsb_owner_e next_ddcDataOwner;  // Data pad owner
    scgsb_owner_e next_ddcClockOwner; // Clock pad owner
    scgsb_pad_s   next_padCtrl;       // Full pad control word
    logic         next_fuseUserClkEn; // Fuse clock enable
    logic         fusePhase;          // Divide-by-2 phase

    // Override beats routing bit for each display pad
    // Owner code decoded separately for each pad
    assign next_ddcDataOwner =
        overrideWord[OVR_DDC_DATA] ? OWN_SW :
        routeWord[RT_DDC_DATA]     ? OWN_SERIAL : OWN_HDMI;
    assign next_ddcClockOwner =
        overrideWord[OVR_DDC_CLOCK] ? OWN_SW :
        routeWord[RT_DDC_CLOCK]     ? OWN_SERIAL : OWN_HDMI;

    // Collect the routing word into the pad carrier
    assign next_padCtrl = '{
        ddcDataOwner:        next_ddcDataOwner,
        ddcClockOwner:       next_ddcClockOwner,
        cardPowerPrimary:    routeWord[RT_CARD_PWR],
        tempConvClockInvert: !routeWord[RT_TEMP_CLK],
        wifiClkFromOsc:      routeWord[RT_WIFI_SRC],
        audioOutDisable:     routeWord[RT_AUDIO_LSB +: 3],
        aonPadOut:           routeWord[RT_AON_OUT],
        aonPadOutEnN:        routeWord[RT_AON_OE_N],
        aonPadPull:          routeWord[RT_PULL_LSB +: 2],
        ddcInputCond:        routeWord[RT_COND_LSB +: 4]
    };

    // Full rate when clear, every second cycle when set
    // Enable pulse, not a divided clock: no
    // second clock tree, one cycle of lag
    assign next_fuseUserClkEn =
        miscWord[MISC_FUSE_DIV] ? fusePhase : 1'b1;

    // Register derived outputs so each leaves from a flop
    // Costs a cycle after a write, but owners
    // never glitch while two route bits move
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // What the reset routing word decodes to
            padCtrl       <= '{default: '0,
                               ddcDataOwner: OWN_HDMI,
                               ddcClockOwner: OWN_HDMI,
                               tempConvClockInvert: 1'b1,
                               aonPadPull: 2'b10,
                               ddcInputCond: 4'hF};
            fusePhase     <= 1'b0;
            fuseUserClkEn <= 1'b0;
            cardDetect    <= 1'b0;
        end else begin
            padCtrl       <= next_padCtrl;
            fusePhase     <= !fusePhase;
            fuseUserClkEn <= next_fuseUserClkEn;
            cardDetect    <= cardSync ^ miscWord[MISC_CARD_INV];
        end
    end

    // ====================================================================
    // Read-only words
    logic [31:0] statusWord; // Snapshot of status sources
    logic [31:0] ackWord;    // Acknowledge levels

    // Upper reserved bits and bit 17 are tied to zero
    // Sources share clk: no synchroniser
    assign statusWord = {
        4'h0,
        statusIn.encoderVideoQuiet,
        padSync,
        statusIn.audioCodecMasterFlag,
        statusIn.internalMacPhyMode,
        statusIn.vdacCableDetect,
        statusIn.dispDmaDone,
        1'b0,
        statusIn.timerRunning,
        statusIn.externalMacPortMode,
        statusIn.fuseProgBusyNonsecure,
        statusIn.fuseUserBusyNonsecure,
        statusIn.fuseProgBusySecure,
        7'h00
    };

    // Acknowledge passes as is: 0 while asserted
    // Software sees the raw level
    assign ackWord = {22'h000000, sleepAcknowledge};

    // ====================================================================
    // Read selection; write mask half always reads zero
    // Reads change no stored word
    assign readWord =
        (paddr == OFS_PAD_OVERRIDE) ? {30'h00000000, overrideWord} :
        (paddr == OFS_IDLE_REQ)     ? {16'h0000, idleReqWord} :
        (paddr == OFS_IDLE_POLICY)  ? {16'h0000, policyWord} :
        (paddr == OFS_MISC_CLK)     ? {29'h00000000, miscWord} :
        (paddr == OFS_TEMP_HIGH)    ? {16'h0000, tempTestHigh} :
        (paddr == OFS_TEMP_LOW)     ? {16'h0000, tempTestLow} :
        (paddr == OFS_PAD_ROUTE)    ? {16'h0000, routeWord} :
        (paddr == OFS_STATUS)       ? statusWord :
        (paddr == OFS_ACK_STATUS)   ? ackWord : 32'h00000000;

    // Unmapped addresses answer with an error
    // Status words are mapped; writes dropped
    assign addrHit =
        (paddr == OFS_PAD_OVERRIDE) || (paddr == OFS_IDLE_REQ)  ||
        (paddr == OFS_IDLE_POLICY)  || (paddr == OFS_MISC_CLK)  ||
        (paddr == OFS_TEMP_HIGH)    || (paddr == OFS_TEMP_LOW)  ||
        (paddr == OFS_PAD_ROUTE)    || (paddr == OFS_STATUS)    ||
        (paddr == OFS_ACK_STATUS);

    // ====================================================================
    // Bus answer: one access cycle, read data caught at setup
    // Catching at setup keeps prdata a flop; status is one cycle old
    // No wait states: access follows setup
    // A write setup clears prdata to zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (setupPhase) begin
            pready  <= 1'b1;
            pslverr <= !addrHit;
            prdata  <= pwrite ? 32'h00000000 : readWord;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : scgsb_bank

`default_nettype wire

// >>> verification/scgsb_bank_props.sv
// Checker: APB timing and register update rules of the control bank
`timescale 1ns/1ps
`default_nettype none

module scgsb_bank_props
    import scgsb_pkg::*;
(
    input wire logic         clk,
    input wire logic         rstn,
    input wire logic [11:0]  paddr,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [31:0]  pwdata,
    input wire logic         pready,
    input wire logic [31:0]  prdata,
    input wire logic         pslverr,
    input wire logic [9:0]   sleepReq,
    input wire logic [15:0]  sleepAccessStallSel,
    input wire logic         pllClampEn,
    input wire logic [15:0]  tempTestHigh,
    input wire logic [15:0]  tempTestLow,
    input wire scgsb_pad_s   padCtrl
);
    // ====================================================================
    // Helpers
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic mapped; // Address decodes to a word
    assign mapped = paddr inside {OFS_PAD_OVERRIDE, OFS_IDLE_REQ, OFS_IDLE_POLICY,
        OFS_MISC_CLK, OFS_TEMP_HIGH, OFS_TEMP_LOW, OFS_PAD_ROUTE, OFS_STATUS,
        OFS_ACK_STATUS};
    // Completed write to one word
    sequence s_wr(ofs);
        psel && penable && pready && pwrite && paddr == ofs;
    endsequence
    // Setup cycle of any transfer
    sequence s_setup;
        psel && !penable;
    endsequence

    // ====================================================================
    // Assertions
    a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
        else $error("pready not a one-cycle answer to setup");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr disagrees with address decode");
    a_req_masked: assert property (s_wr(OFS_IDLE_REQ) |=> sleepReq ==
        (($past(sleepReq) & ~$past(pwdata[25:16])) | ($past(pwdata[9:0]) & $past(pwdata[25:16]))))
        else $error("sleep request word ignores write mask");
    a_policy_masked: assert property (s_wr(OFS_IDLE_POLICY) |=> sleepAccessStallSel ==
        (($past(sleepAccessStallSel) & ~$past(pwdata[31:16]))
        | ($past(pwdata[15:0]) & $past(pwdata[31:16]))))
        else $error("policy word ignores write mask");
    a_clamp_set: assert property (s_wr(OFS_MISC_CLK) |=> pllClampEn == $past(pwdata[1]))
        else $error("clamp enable not taken from write");
    a_temp_hold: assert property (!(psel && penable && pready && pwrite
        && paddr == OFS_TEMP_HIGH) |=> $stable(tempTestHigh))
        else $error("sensor high word changed without a write");
    a_temp_low: assert property (s_wr(OFS_TEMP_LOW) |=> tempTestLow ==
        (($past(tempTestLow) & ~$past(pwdata[31:16]))
        | ($past(pwdata[15:0]) & $past(pwdata[31:16]))))
        else $error("sensor low word ignores write mask");
    a_cond_reset: assert property ($rose(rstn) |-> padCtrl.ddcInputCond == 4'hF
        && padCtrl.aonPadPull == 2'h2)
        else $error("pad conditioning or pull reset value wrong");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=>
        prdata == ($past(psel && !penable) ? 32'h00000000 : $past(prdata)))
        else $error("read data changed outside a read");
endmodule : scgsb_bank_props

bind scgsb_bank scgsb_bank_props u_props (.clk(clk), .rstn(rstn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .sleepReq(sleepReq),
    .sleepAccessStallSel(sleepAccessStallSel), .pllClampEn(pllClampEn),
    .tempTestHigh(tempTestHigh), .tempTestLow(tempTestLow), .padCtrl(padCtrl));

`default_nettype wire

// >>> verification/scgsb_bank_tb_top.sv
// Testbench: control bank driven over APB, table cases then hand-written cases
`timescale 1ns/1ps
`default_nettype none

module scgsb_bank_tb_top
    import scgsb_pkg::*;
;
    // ====================================================================
    // Signals
    logic          clk, rstn, psel, penable, pwrite, pready, pslverr, err, f0;
    logic          fuseUserClkEn, pllClampEn, cardDetect, cardDetectPin;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic [14:0]   stVec;             // Status sources, struct order
    logic [9:0]    sleepAcknowledge, sleepReq;
    logic [4:0]    padLevelPin;
    logic [5:0]    sleepPolicyA;
    logic [15:0]   sleepAccessStallSel, tempTestHigh, tempTestLow;
    scgsb_pad_s    padCtrl;
    scgsb_status_s statusIn;
    int            n_fail, samples_checked, cycles;
    assign statusIn = scgsb_status_s'(stVec);
    logic [3:0]    owners;            // Data and clock pad owners
    assign owners = {padCtrl.ddcDataOwner, padCtrl.ddcClockOwner};

    scgsb_bank u_dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .statusIn(statusIn),
        .sleepAcknowledge(sleepAcknowledge), .padLevelPin(padLevelPin),
        .cardDetectPin(cardDetectPin), .sleepReq(sleepReq), .sleepPolicyA(sleepPolicyA),
        .sleepAccessStallSel(sleepAccessStallSel), .fuseUserClkEn(fuseUserClkEn),
        .pllClampEn(pllClampEn), .cardDetect(cardDetect), .tempTestHigh(tempTestHigh),
        .tempTestLow(tempTestLow), .padCtrl(padCtrl));

    // ====================================================================
    // Table: address, write data, read-back
    logic [11:0] rstAddr [6] = '{OFS_IDLE_REQ, OFS_IDLE_POLICY, OFS_MISC_CLK,
        OFS_TEMP_HIGH, OFS_TEMP_LOW, OFS_PAD_ROUTE};
    logic [75:0] rows [10] = '{
        {OFS_IDLE_REQ, 32'h03FF_03FF, 32'h0000_03FF},
        {OFS_IDLE_REQ, 32'h0001_0000, 32'h0000_03FE},
        {OFS_IDLE_REQ, 32'hFC00_FFFF, 32'h0000_FFFE},
        {OFS_IDLE_POLICY, 32'hFFFF_A5A5, 32'h0000_A5A5},
        {OFS_IDLE_POLICY, 32'hFF00_0000, 32'h0000_00A5},
        {OFS_MISC_CLK, 32'hFFFF_FFFF, 32'h0000_0007},
        {OFS_MISC_CLK, 32'h0000_0002, 32'h0000_0002},
        {OFS_TEMP_HIGH, 32'hFFFF_1234, 32'h0000_1234},
        {OFS_TEMP_LOW, 32'h00FF_ABCD, 32'h0000_00CD},
        {OFS_PAD_ROUTE, 32'hFFFF_0000, 32'h0000_0000}};

    // ====================================================================
    // Clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin // Run needs well under 1000
            n_fail++;
            finish_test();
        end
    end

    // ====================================================================
    // Tasks
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : chk
    // One APB transfer; values read before this edge's updates land
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1); // Waits for pready; the hang guard ends a stall
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk); // Idle cycle: strobes never set twice in one step
    endtask : apb
    task rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(name, exp, rd);
    endtask : rdc
    // Reset values of every control word except the pad override
    task reset_reads;
        foreach (rstAddr[i]) rdc("reset word", rstAddr[i],
            (rstAddr[i] == OFS_PAD_ROUTE) ? 32'h0000_F800 : 32'h0);
    endtask : reset_reads
    task finish_test;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // ====================================================================
    // Main sequence
    initial begin
        clk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        stVec = 0; sleepAcknowledge = 0; padLevelPin = 0; cardDetectPin = 1;
        n_fail = 0; samples_checked = 0; cycles = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        reset_reads();
        foreach (rows[i]) begin
            apb(rows[i][75:64], 1'b1, rows[i][63:32]);
            rdc("table word", rows[i][75:64], rows[i][31:0]);
        end
        chk("sleep requests", 32'h3FE, sleepReq);
        chk("stall select", 32'h00A5, sleepAccessStallSel);
        chk("policy upper", 32'h003F, sleepPolicyA);
        chk("fuse clock", 32'h1, fuseUserClkEn);
        // Divide by two, card detect passes through
        apb(OFS_MISC_CLK, 1'b1, 32'h4);
        repeat (3) @(posedge clk);
        f0 = fuseUserClkEn;
        @(posedge clk);
        chk("fuse clock alternates", !f0, fuseUserClkEn);
        chk("card detect", 32'h1, cardDetect);
        apb(OFS_MISC_CLK, 1'b1, 32'h1);
        repeat (3) @(posedge clk);
        chk("card detect inverted", 32'h0, cardDetect);
        // Pad routing fields, then owner priority
        apb(OFS_PAD_ROUTE, 1'b1, 32'h03FF_0275);
        repeat (3) @(posedge clk);
        chk("route outputs", {1'b1, 1'b0, 1'b1, 3'b101, 1'b0, 1'b1},
            {padCtrl.cardPowerPrimary, padCtrl.tempConvClockInvert, padCtrl.wifiClkFromOsc,
            padCtrl.audioOutDisable, padCtrl.aonPadOut, padCtrl.aonPadOutEnN});
        chk("owners display", {OWN_HDMI, OWN_HDMI}, owners);
        apb(OFS_PAD_ROUTE, 1'b1, 32'h0180_0180);
        repeat (3) @(posedge clk);
        chk("owners serial", {OWN_SERIAL, OWN_SERIAL}, owners);
        apb(OFS_PAD_OVERRIDE, 1'b1, 32'h0002_0002);
        repeat (3) @(posedge clk);
        chk("owner override", {OWN_SW, OWN_SERIAL}, owners);
        // Status snapshot, two patterns, write ignored
        for (int k = 0; k < 2; k++) begin
            stVec <= k ? 15'h2AAA : 15'h5555;
            padLevelPin <= k ? 5'h0A : 5'h15;
            repeat (4) @(posedge clk);
            apb(OFS_STATUS, 1'b1, 32'hFFFF_FFFF);
            rdc("status", OFS_STATUS, {4'h0, stVec[14], padLevelPin,
                stVec[13], stVec[12:10], 1'b0, stVec[9:0], 7'h00});
        end
        sleepAcknowledge <= 10'h2A5;
        @(posedge clk);
        rdc("ack status", OFS_ACK_STATUS, 32'h0000_02A5);
        // Unmapped address
        rdc("unmapped read", 12'h500, 32'h0);
        chk("unmapped read error", 32'h1, err);
        apb(12'h500, 1'b1, 32'hFFFF_FFFF);
        chk("unmapped write error", 32'h1, err);
        // Second reset in mid-run
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        reset_reads();
        chk("pull after reset", 32'h2, padCtrl.aonPadPull);
        finish_test();
    end
endmodule : scgsb_bank_tb_top

`default_nettype wire
